/* pfs_pkg.sv */
// Package of constants and carrier types for the fault shutdown block.
package pfs_pkg;

    localparam int STAGES = 4;
    localparam int RAILS = 2;
    localparam int CLK_MHZ = 40;

    // Stage order on all vectors: 0 = 1A, 1 = 1B, 2 = 2A, 3 = 3A.
    localparam int IDX_1A = 0;
    localparam int IDX_1B = 1;
    localparam int IDX_2A = 2;
    localparam int IDX_3A = 3;

    // Comparator numbering is 1 to 4; these map stages 1B and 3A to their comparator numbers.
    localparam int CMP_1B = 2;
    localparam int CMP_3A = 4;

    // Latency budgets in microseconds; the first-off switch limit in cycles.
    localparam int EXT_BASE_US = 15;
    localparam int CMP_BASE_US = 10;
    localparam int PER_PHASE_US = 3;
    localparam int FIRST_OFF_SWITCH_CYCLES = 4;

    // Cycle counts derived from the budgets; each is an exact product with CLK_MHZ, nothing rounds.
    localparam int EXT_BASE_CYC = EXT_BASE_US * CLK_MHZ;
    localparam int CMP_BASE_CYC = CMP_BASE_US * CLK_MHZ;
    localparam int PER_PHASE_CYC = PER_PHASE_US * CLK_MHZ;

    // Shutdown acts in this many cycles, well inside every budget.
    localparam int SHUT_DELAY_CYC = 2;

    typedef struct packed {
        logic [STAGES-1:0] pwm;
        logic [STAGES-1:0] rect;
    } pfs_gate_s;

endpackage : pfs_pkg

/* pfs_fault_shutdown.sv */
// Hardware fault shutdown path for the pulse width and rectifier outputs.
module pfs_fault_shutdown #(
    parameter int STAGES = pfs_pkg::STAGES,
    parameter int RAILS = pfs_pkg::RAILS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [STAGES-1:0] ext_fault_in,
    input wire logic [STAGES-1:0] comparator_trip,
    input wire logic [STAGES-1:0] stage_configured,
    input wire logic [STAGES-1:0] stage_rail,
    input wire logic [RAILS-1:0] rail_reenable,
    input wire pfs_pkg::pfs_gate_s gate_request,
    output pfs_pkg::pfs_gate_s gate_out,
    output logic [STAGES-1:0] pulse_width_out,
    output logic [STAGES-1:0] rectifier_enable_out,
    output logic [RAILS-1:0] rail_shutdown,
    output logic [2:0] configured_phase_count,
    output logic [31:0] ext_budget_cycles,
    output logic [31:0] cmp_budget_cycles
);

    logic [STAGES-1:0] cmp_stage;
    logic [STAGES-1:0] ext_hit;
    logic [RAILS-1:0] rail_hit;
    logic [STAGES-1:0] pwm_kill_d, pwm_kill_q;
    logic [RAILS-1:0] rail_kill_d, rail_kill_q;
    logic [STAGES-1:0] mask_pwm_d, mask_pwm_q;
    logic [STAGES-1:0] mask_rect_d, mask_rect_q;
    logic [2:0] phase_d, phase_q;
    logic [STAGES-1:0] stage_rail_kill;
    logic [STAGES-1:0] stage_reenable;
    pfs_pkg::pfs_gate_s gate_d, gate_q;

    // Each stage sees the kill and re-enable of the rail that it is wired to.
    for (genvar g = 0; g < STAGES; g++)
    begin : g_stage
        assign stage_rail_kill[g] = rail_kill_q[stage_rail[g]];
        assign stage_reenable[g] = rail_reenable[stage_rail[g]];
    end

    // Comparator numbers map onto stages; stage 2A on comparator 3, 1A on 1.
    always_comb
    begin
        cmp_stage = '0;
        cmp_stage[pfs_pkg::IDX_1A] = comparator_trip[0];
        cmp_stage[pfs_pkg::IDX_1B] = comparator_trip[pfs_pkg::CMP_1B - 1];
        cmp_stage[pfs_pkg::IDX_2A] = comparator_trip[2];
        cmp_stage[pfs_pkg::IDX_3A] = comparator_trip[pfs_pkg::CMP_3A - 1];
    end

    // Pure combinational detection, no dependence on any sampled sequence.
    always_comb
    begin
        ext_hit = ext_fault_in & stage_configured;
        rail_hit = '0;
        for (int i = 0; i < STAGES; i++)
        begin
            if (cmp_stage[i] && stage_configured[i])
            begin
                rail_hit[stage_rail[i]] = 1'b1;
            end
        end
    end

    always_comb
    begin
        phase_d = '0;
        for (int i = 0; i < STAGES; i++)
        begin
            phase_d = phase_d + 3'(stage_configured[i]);
        end
        pwm_kill_d = ext_hit | (cmp_stage & stage_configured);
        rail_kill_d = rail_hit;
        mask_pwm_d = mask_pwm_q;
        mask_rect_d = mask_rect_q;
        for (int i = 0; i < STAGES; i++)
        begin
            // Re-enable clears the latch, but a kill registered last cycle wins; for the rectifier only a rail kill does, plus an external fault this cycle.
            if (stage_reenable[i])
            begin
                mask_pwm_d[i] = 1'b0;
                mask_rect_d[i] = 1'b0;
            end
            if (pwm_kill_q[i] || stage_rail_kill[i])
            begin
                mask_pwm_d[i] = 1'b1;
            end
            // A rail-wide kill drops the rectifiers too; an external fault only its own.
            if (stage_rail_kill[i] || ext_hit[i])
            begin
                mask_rect_d[i] = 1'b1;
            end
        end
        gate_d.pwm = gate_request.pwm & ~mask_pwm_d;
        gate_d.rect = gate_request.rect & ~mask_rect_d;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pwm_kill_q <= '0;
            rail_kill_q <= '0;
            mask_pwm_q <= '0;
            mask_rect_q <= '0;
            phase_q <= '0;
            gate_q <= '0;
        end
        else
        begin
            pwm_kill_q <= pwm_kill_d;
            rail_kill_q <= rail_kill_d;
            mask_pwm_q <= mask_pwm_d;
            mask_rect_q <= mask_rect_d;
            phase_q <= phase_d;
            gate_q <= gate_d;
        end
    end

    // A rail reports shutdown while any of its stages is held off.
    always_comb
    begin
        rail_shutdown = '0;
        for (int i = 0; i < STAGES; i++)
        begin
            if (mask_pwm_q[i])
            begin
                rail_shutdown[stage_rail[i]] = 1'b1;
            end
        end
    end

    assign gate_out = gate_q;
    assign pulse_width_out = gate_q.pwm;
    assign rectifier_enable_out = gate_q.rect;
    assign configured_phase_count = phase_q;
    assign ext_budget_cycles = 32'(pfs_pkg::EXT_BASE_CYC + pfs_pkg::PER_PHASE_CYC * int'(phase_q));
    assign cmp_budget_cycles = 32'(pfs_pkg::CMP_BASE_CYC + pfs_pkg::PER_PHASE_CYC * int'(phase_q));

    a_ext_fault_off: assert property (@(posedge clk) disable iff (rst)
        ext_fault_in[0] && stage_configured[0] |-> ##[1:3] !pulse_width_out[0])
        else $error("external fault did not disable pwm");
    a_ext_active_high: assert property (@(posedge clk) disable iff (rst)
        ext_fault_in[1] && stage_configured[1] |-> ##2 !pulse_width_out[1])
        else $error("high fault level did not disable stage");
    a_cmp_first_off: assert property (@(posedge clk) disable iff (rst)
        comparator_trip[0] && stage_configured[0] |-> ##[1:3] !pulse_width_out[0])
        else $error("comparator trip did not stop first output");
    a_cmp_rail_off: assert property (@(posedge clk) disable iff (rst)
        comparator_trip[2] && stage_configured[2] && stage_rail[2] == stage_rail[0] && !rail_reenable[stage_rail[0]]
        |-> ##2 !pulse_width_out[0] && !rectifier_enable_out[0])
        else $error("rail mate not disabled after comparator trip");
    a_cmp4_stage3a: assert property (@(posedge clk) disable iff (rst)
        comparator_trip[3] && stage_configured[3] |-> ##2 !pulse_width_out[3])
        else $error("comparator four not attributed to 3A");
    a_cmp2_stage1b: assert property (@(posedge clk) disable iff (rst)
        comparator_trip[1] && stage_configured[1] |-> ##2 !pulse_width_out[1])
        else $error("comparator two not attributed to 1B");
    a_phase_count: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> configured_phase_count == 3'($countones($past(stage_configured))))
        else $error("phase count mismatch");
    a_rect_low_off: assert property (@(posedge clk) disable iff (rst)
        ext_fault_in[2] && stage_configured[2] |-> ##2 !rectifier_enable_out[2])
        else $error("rectifier enable not driven low");
    a_latch_holds: assert property (@(posedge clk) disable iff (rst)
        mask_pwm_q[0] && !rail_reenable[stage_rail[0]] |=> mask_pwm_q[0])
        else $error("shutdown latch released without re-enable");

    // Stage 2A first-off, rail mates, rectifiers, rail flags, unconfigured stages, re-enable and power-up.
    a_cmp_first_2a: assert property (@(posedge clk) disable iff (rst)
        comparator_trip[2] && stage_configured[2] |-> ##[1:3] !pulse_width_out[2])
        else $error("comparator trip did not stop stage 2A output");
    a_rail1_mate_off: assert property (@(posedge clk) disable iff (rst)
        comparator_trip[3] && stage_configured[3] && stage_rail[1] == stage_rail[3]
        |-> ##2 !pulse_width_out[1] && !rectifier_enable_out[1])
        else $error("rail one mate not disabled after comparator trip");
    a_cmp_rail_flag: assert property (@(posedge clk) disable iff (rst)
        comparator_trip[0] && stage_configured[0] |-> ##2 rail_shutdown[stage_rail[0]])
        else $error("rail shutdown flag missing after comparator trip");
    a_ext_rail_flag: assert property (@(posedge clk) disable iff (rst)
        ext_fault_in[2] && stage_configured[2] |-> ##2 rail_shutdown[stage_rail[2]])
        else $error("rail shutdown flag missing after external fault");
    a_cmp3a_rect_off: assert property (@(posedge clk) disable iff (rst)
        comparator_trip[3] && stage_configured[3] |-> ##2 !rectifier_enable_out[3])
        else $error("comparator four did not drop rectifier of 3A");
    a_cmp1b_rect_off: assert property (@(posedge clk) disable iff (rst)
        comparator_trip[1] && stage_configured[1] |-> ##2 !rectifier_enable_out[1])
        else $error("comparator two did not drop rectifier of 1B");
    a_unconfig_ignored: assert property (@(posedge clk) disable iff (rst)
        ext_fault_in[0] && !stage_configured[0] |=> !pwm_kill_q[0])
        else $error("fault on unconfigured stage was acted on");
    a_rect_own_fast: assert property (@(posedge clk) disable iff (rst)
        ext_fault_in[3] && stage_configured[3] |-> ##1 !rectifier_enable_out[3])
        else $error("rectifier enable not dropped on own fault");
    a_reenable_clears: assert property (@(posedge clk) disable iff (rst)
        rail_reenable[stage_rail[0]] && !pwm_kill_q[0] && !rail_kill_q[stage_rail[0]] |=> !mask_pwm_q[0])
        else $error("re-enable did not release pulse output");
    a_rect_reenable: assert property (@(posedge clk) disable iff (rst)
        rail_reenable[stage_rail[2]] && !rail_kill_q[stage_rail[2]] && !ext_hit[2] |=> !mask_rect_q[2])
        else $error("re-enable did not release rectifier");
    a_rect_latch_holds: assert property (@(posedge clk) disable iff (rst)
        mask_rect_q[1] && !rail_reenable[stage_rail[1]] |=> mask_rect_q[1])
        else $error("rectifier latch released without re-enable");
    a_powerup_clears: assert property (@(posedge clk)
        rst |=> mask_pwm_q == '0 && mask_rect_q == '0)
        else $error("reset did not release shutdown latches");

    c_ext_fault: cover property (@(posedge clk) disable iff (rst) ext_hit[0] ##2 !pulse_width_out[0]);
    c_cmp_rail: cover property (@(posedge clk) disable iff (rst) |rail_hit ##2 |rail_shutdown);
    c_reenable: cover property (@(posedge clk) disable iff (rst) rail_shutdown[0] ##1 rail_reenable[0]);
    c_rect_fast: cover property (@(posedge clk) disable iff (rst) ext_hit[3] ##1 !rectifier_enable_out[3]);
    c_unconfig_fault: cover property (@(posedge clk) disable iff (rst) ext_fault_in[0] && !stage_configured[0]);

endmodule // pfs_fault_shutdown

/* pfs_stage_model.sv */
// Power stage and fault source model that faces the shutdown block.
module pfs_stage_model (
    input wire logic [3:0] fault_cmd,
    input wire logic [7:0] req_cmd,
    output logic [3:0] ext_fault_in,
    output pfs_pkg::pfs_gate_s gate_request
);
    timeunit 1ns;
    timeprecision 1ps;
    // A fault source holds its level for as long as the bench commands it.
    always_comb
    begin
        ext_fault_in = fault_cmd;
        gate_request = pfs_pkg::pfs_gate_s'(req_cmd);
    end
endmodule // pfs_stage_model

/* pfs_fault_shutdown_bench.sv */
// Self-checking bench for the fault shutdown block.
module pfs_fault_shutdown_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1;
    logic [3:0] fault_cmd = 0, cmp = 0, cfg = 4'hF, rail_of = 4'hA, m;
    logic [1:0] reen = 0, rshut;
    logic [7:0] req_cmd = 8'hFF;
    logic [3:0] ext, pwm, rect;
    logic [2:0] phases;
    logic [31:0] eb, cb;
    pfs_pkg::pfs_gate_s req, gout;
    int failures = 0, compares = 0;
    logic [34:0] q[$];
    logic [34:0] e;
    logic [31:0] obs;
    event chk;
    always #12.5 clk = ~clk;
    pfs_stage_model PM (.fault_cmd(fault_cmd), .req_cmd(req_cmd), .ext_fault_in(ext), .gate_request(req));
    pfs_fault_shutdown DUT (.clk(clk), .rst(rst), .ext_fault_in(ext), .comparator_trip(cmp),
        .stage_configured(cfg), .stage_rail(rail_of), .rail_reenable(reen), .gate_request(req),
        .gate_out(gout), .pulse_width_out(pwm), .rectifier_enable_out(rect), .rail_shutdown(rshut),
        .configured_phase_count(phases), .ext_budget_cycles(eb), .cmp_budget_cycles(cb));
    task conclude;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Gate expectations are checked on the separate outputs and on the struct.
    task note(input logic [2:0] k, input logic [31:0] v);
        q.push_back({k, v});
        if (k == 3'h0)
            q.push_back({3'h5, v});
        ->chk;
    endtask
    function automatic string kind_name(input logic [2:0] k);
        case (k)
            3'h0: return "gates";
            3'h1: return "ext_budget";
            3'h2: return "cmp_budget";
            3'h3: return "phase_count";
            3'h4: return "rail_shutdown";
            default: return "gate_out";
        endcase
    endfunction
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task rearm;
        fault_cmd = 0;
        cmp = 0;
        // Let kills still in flight land first, since a fault beats re-enable.
        cyc(2);
        reen = 2'h3;
        cyc(1);
        reen = 0;
        cyc(3);
        note(0, 32'hFF);
        note(4, 32'h0);
    endtask
    always
    begin
        @(chk);
        while (q.size() > 0)
        begin
            e = q.pop_front();
            obs = e[34:32] == 0 ? {24'h0, pwm, rect} : e[34:32] == 1 ? eb : e[34:32] == 2 ? cb :
                e[34:32] == 3 ? {29'h0, phases} : e[34:32] == 4 ? {30'h0, rshut} : {24'h0, gout};
            compares++;
            if (obs !== e[31:0])
            begin
                failures++;
                $display("BAD %s exp %h got %h", kind_name(e[34:32]), e[31:0], obs);
            end
        end
    end
    initial
    begin
        void'($urandom(41));
        cyc(10);
        rst = 0;
        cyc(2);
        note(1, pfs_pkg::EXT_BASE_CYC + 4 * pfs_pkg::PER_PHASE_CYC);
        note(2, pfs_pkg::CMP_BASE_CYC + 4 * pfs_pkg::PER_PHASE_CYC);
        note(3, 32'h4);
        for (int s = 0; s < 4; s++)
        begin
            m = 4'h1 << s;
            fault_cmd = m;
            cyc(2);
            note(0, {24'h0, ~m, ~m});
            note(4, 32'h1 << rail_of[s]);
            fault_cmd = 0;
            cyc(3);
            note(0, {24'h0, ~m, ~m});
            rearm;
        end
        // Comparator n sits on bit n-1, so bits 1 and 3 are stages 1B and 3A.
        for (int n = 1; n <= 4; n++)
        begin
            cmp = 4'h1 << (n - 1);
            m = rail_of[n-1] ? rail_of : ~rail_of;
            cyc(2);
            note(0, {24'h0, ~m, ~m});
            note(4, 32'h1 << rail_of[n-1]);
            rearm;
        end
        cfg = 4'hE;
        fault_cmd = 4'h1;
        cyc(3);
        note(0, 32'hFF);
        note(4, 32'h0);
        note(3, 32'h3);
        note(1, pfs_pkg::EXT_BASE_CYC + 3 * pfs_pkg::PER_PHASE_CYC);
        cfg = 4'hF;
        rearm;
        repeat (8)
        begin
            req_cmd = 8'($urandom);
            cyc(3);
            note(0, {24'h0, req_cmd});
        end
        cyc(1);
        conclude;
    end
    initial
    begin
        #(25 * 2000);
        failures++;
        conclude;
    end
endmodule // pfs_fault_shutdown_bench
